// *** drs_motor_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module drs_motor_model #(
   parameter logic [15:0] RATE = 16'h0040
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire drs_pkg::drs_cmd_t cmd,
   output logic [15:0] outFreqNow
);
   logic [15:0] speed_r;
   logic [15:0] targetSpeed;
   // ---
   // Shaft speed
   // ---
   // Only a driven run pulls speed up; coast and braking shed it, never hold it
   assign targetSpeed = (cmd.run && !cmd.coast && !cmd.dcBrake) ? cmd.freq : 16'h0000;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         speed_r <= 16'h0000;
      end else if (speed_r + RATE <= targetSpeed) begin
         speed_r <= speed_r + RATE;
      end else if (speed_r >= targetSpeed + RATE) begin
         speed_r <= speed_r - RATE;
      end else begin
         speed_r <= targetSpeed;
      end
   end
   assign outFreqNow = speed_r;
endmodule // drs_motor_model
`default_nettype wire

// *** drs_pkg.sv ***
package drs_pkg;
   // ----------------------------------------
   // Setting encodings
   // ----------------------------------------
   localparam logic [2:0] SEQ_OFF = 3'h0;
   localparam logic [2:0] SEQ_RESUME_MAX = 3'h3;
   localparam logic [1:0] DIR_STOP = 2'h0;
   localparam logic [1:0] DIR_FWD = 2'h1;
   localparam logic [1:0] DIR_REV = 2'h2;
   localparam int NUM_STEPS = 8;
   localparam logic [3:0] MAX_ATTEMPTS = 4'hA;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int TENTH_S_NS = 100_000_000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_CYCLES = TENTH_S_NS / CLK_PERIOD_NS;
   localparam int FIXED_WAIT_MS = 500;
   localparam logic [13:0] FIXED_WAIT_TENTHS = 14'h0005;
   localparam logic [13:0] MAX_DELAY_TENTHS = 14'h1F40;
   localparam logic [7:0] MAX_DCB_TENTHS = 8'hFF;
   localparam logic [15:0] MIN_DCB_FREQ = 16'h000A;
   localparam logic [15:0] MAX_DCB_FREQ = 16'h03E8;
   localparam logic [4:0] MAX_DCB_LEVEL = 5'h14;
   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [15:0] freq;   // 0.01 Hz units
      logic [15:0] time10; // 0.1 s units
      logic [1:0] dir;
   } drs_step_t;
   typedef struct packed {
      logic [15:0] freq;
      logic [1:0] dir;
      logic run;
      logic accelSet2;
      logic coast;
      logic dcBrake;
      logic [4:0] dcLevel;
   } drs_cmd_t;
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_RUN = 6'b000010,
      ST_DECEL = 6'b000100,
      ST_BRAKE = 6'b001000,
      ST_FAULT = 6'b010000,
      ST_WAIT = 6'b100000
   } drs_state_t;
endpackage

// *** drs_sequencer.sv ***
// What this block does
// - Single-cycle modes run every configured step once, then stop output.
// - Periodic modes wrap from last step to first, forever while running.
// - Hold modes keep running at final step frequency after one cycle.
// - Modes one to three resume from the unfinished step after interruption.
// - Modes four to six restart at step zero after interruption, except when run returns during deceleration.
// - Sequencer ramps use the global accel/decel set one or two.
// - Step zero frequency comes from keypad; time and direction from step-zero settings.
// - Step direction: zero stop, one forward, two reverse.
// - Under-voltage removes output drive immediately while running; deceleration and DC braking carry on.
// - Power-loss restart disabled: no self-start after supply returns.
// - Power-loss restart enabled: resume at prior frequency, unlimited times.
// - Power-loss restart needs processor alive and run switch on; run source and direct-start are not checked.
// - Fault restart attempts zero to ten; zero forbids auto restart.
// - Nonzero attempts, zero delay: restart at prior frequency after fixed wait.
// - Nonzero delay: wait programmed delay, zero to 800.0 s in tenths; larger settings are waited unclamped.
// - No fault auto-restart during DC braking or decelerating to stop.
// - Reset mode zero: fault reset accepted only with run command off.
// - Reset mode one: fault reset accepted with run on or off.
// - Direct start enabled, external source: run switch on at power-up starts.
// - Direct start disabled, external source: switch on at power-up blocks start and flashes indication.
// - DC braking clamps the level to its maximum; start frequency and duration are used as set, unclamped.
// - Stop method zero ramps down using the globally selected accel/decel set one or two.
// - Stop method one removes drive at once, motor coasts.
`timescale 1ns/1ps
`default_nettype none
module drs_sequencer #(
   parameter int TICK = drs_pkg::TICK_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic runSwitchPin,
   input wire logic faultResetPin,
   input wire logic seqEnablePin,
   input wire logic underVoltagePin,
   input wire logic faultTrip,
   input wire logic cpuPowerOk,
   input wire logic extRunSource,
   input wire logic [2:0] seqMode,
   input wire drs_pkg::drs_step_t [drs_pkg::NUM_STEPS-1:0] steps,
   input wire logic [15:0] keypadFreq,
   input wire logic [15:0] outFreqNow,
   input wire logic accelSet2,
   input wire logic powerLossRestart,
   input wire logic [13:0] restartDelay,
   input wire logic [3:0] restartAttempts,
   input wire logic resetMode,
   input wire logic directStartOff,
   input wire logic [15:0] dcStartFreq,
   input wire logic [4:0] dcLevel,
   input wire logic [7:0] dcTime,
   input wire logic stopMethod,
   output drs_pkg::drs_cmd_t cmd,
   output logic [2:0] stepIdx,
   output logic faulted,
   output logic startBlockedIndication
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [4:0] syncA_r, syncB_r;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         syncA_r <= 5'h00;
         syncB_r <= 5'h00;
      end else begin
         syncA_r <= {runSwitchPin, faultResetPin, seqEnablePin, underVoltagePin, faultTrip};
         syncB_r <= syncA_r;
      end
   end
   logic runSw, rstReq, seqEn, uv, trip;
   assign {runSw, rstReq, seqEn, uv, trip} = syncB_r;

   // ----------------------------------------
   // Tenth-second tick
   // ----------------------------------------
   logic [31:0] divCnt_r;
   logic tick;
   assign tick = (divCnt_r == 32'(TICK - 1));
   always_ff @(posedge ref_clk) begin
      if (rst || tick) divCnt_r <= 32'h0000_0000;
      else divCnt_r <= divCnt_r + 32'h0000_0001;
   end

   // ----------------------------------------
   // Run switch edges and power-up check
   // ----------------------------------------
   logic runPrev_r, firstSample_r, blocked_r, puStart_r;
   logic runRise;
   assign runRise = runSw && !runPrev_r;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         runPrev_r <= 1'b0;
         firstSample_r <= 1'b1;
         blocked_r <= 1'b0;
         puStart_r <= 1'b0;
      end else begin
         runPrev_r <= runSw;
         // One-cycle start request when the switch is already on at power-up
         puStart_r <= firstSample_r && divCnt_r == 32'h0000_0002 && runSw && extRunSource
            && !directStartOff;
         if (firstSample_r && divCnt_r == 32'h0000_0002) begin
            firstSample_r <= 1'b0;
            // Switch already on at power-up
            if (runSw && extRunSource && directStartOff) blocked_r <= 1'b1;
         end else if (!runSw) begin
            blocked_r <= 1'b0;
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      // Blinks at the tick rate
      if (rst) startBlockedIndication <= 1'b0;
      else startBlockedIndication <= blocked_r && divCnt_r < 32'(TICK / 2);
   end

   // ----------------------------------------
   // Main state machine
   // ----------------------------------------
   drs_pkg::drs_state_t state_r;
   logic [2:0] step_r;
   logic [15:0] stepTime_r, heldFreq_r, waitCnt_r;
   logic [3:0] tries_r;
   logic cycleDone_r, uvSeen_r;
   drs_pkg::drs_step_t cur;
   logic seqMode_on, resumeMode, periodic, holdMode, stepUnused, lastStep;
   always_comb begin
      cur = steps[step_r];
      if (step_r == 3'h0) cur.freq = keypadFreq;
   end
   assign seqMode_on = seqEn && seqMode != drs_pkg::SEQ_OFF;
   assign resumeMode = seqMode <= drs_pkg::SEQ_RESUME_MAX;
   assign periodic = seqMode == 3'h2 || seqMode == 3'h5;
   assign holdMode = seqMode == 3'h3 || seqMode == 3'h6;
   assign stepUnused = cur.freq == 16'h0000 && cur.time10 == 16'h0000;
   logic [2:0] nextStep;
   assign nextStep = step_r + 3'h1;
   assign lastStep = step_r == 3'h7 || (steps[nextStep].freq == 16'h0000
      && steps[nextStep].time10 == 16'h0000);
   logic runOk;
   // Nothing starts before the power-up switch check has run
   assign runOk = runSw && !blocked_r && !uv && !firstSample_r;
   logic resetOk;
   assign resetOk = rstReq && (resetMode || !runSw);
   logic [13:0] delayTenths;
   assign delayTenths = (restartDelay == 14'h0000) ? drs_pkg::FIXED_WAIT_TENTHS
      : restartDelay;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_r <= drs_pkg::ST_IDLE;
         step_r <= 3'h0;
         stepTime_r <= 16'h0000;
         heldFreq_r <= 16'h0000;
         waitCnt_r <= 16'h0000;
         tries_r <= 4'h0;
         cycleDone_r <= 1'b0;
         uvSeen_r <= 1'b0;
      end else begin
         if (uv && state_r == drs_pkg::ST_RUN) begin
            uvSeen_r <= powerLossRestart && cpuPowerOk;
            heldFreq_r <= outFreqNow;
            state_r <= drs_pkg::ST_IDLE;
            if (!resumeMode) step_r <= 3'h0;
         end else if (trip && state_r != drs_pkg::ST_FAULT && state_r != drs_pkg::ST_WAIT) begin
            heldFreq_r <= outFreqNow;
            if (!resumeMode) step_r <= 3'h0;
            // Braking or stopping suppresses retry
            if (restartAttempts != 4'h0 && tries_r < restartAttempts && tries_r < drs_pkg::MAX_ATTEMPTS
                && state_r != drs_pkg::ST_BRAKE && state_r != drs_pkg::ST_DECEL) begin
               state_r <= drs_pkg::ST_WAIT;
               waitCnt_r <= {2'h0, delayTenths};
            end else begin
               state_r <= drs_pkg::ST_FAULT;
            end
         end else begin
            case (state_r)
               drs_pkg::ST_IDLE: begin
                  if (uvSeen_r && !uv && runOk) begin
                     uvSeen_r <= 1'b0;
                     state_r <= drs_pkg::ST_RUN;
                  end else if (runRise && runOk) begin
                     heldFreq_r <= 16'h0000;
                     cycleDone_r <= 1'b0;
                     if (!resumeMode) step_r <= 3'h0;
                     stepTime_r <= 16'h0000;
                     state_r <= drs_pkg::ST_RUN;
                  end else if (puStart_r && runOk) begin
                     state_r <= drs_pkg::ST_RUN;
                  end
                  if (!runSw) uvSeen_r <= uvSeen_r && powerLossRestart;
               end
               drs_pkg::ST_RUN: begin
                  if (!runSw) begin
                     tries_r <= 4'h0;
                     if (stopMethod) state_r <= drs_pkg::ST_IDLE;
                     else state_r <= drs_pkg::ST_DECEL;
                  end else if (seqMode_on && !cycleDone_r && tick) begin
                     if (stepTime_r + 16'h0001 >= cur.time10) begin
                        stepTime_r <= 16'h0000;
                        if (lastStep || stepUnused) begin
                           if (periodic) step_r <= 3'h0;
                           else if (holdMode) cycleDone_r <= 1'b1;
                           else begin
                              step_r <= 3'h0;
                              state_r <= drs_pkg::ST_DECEL;
                           end
                        end else begin
                           step_r <= nextStep;
                        end
                     end else begin
                        stepTime_r <= stepTime_r + 16'h0001;
                     end
                  end
               end
               drs_pkg::ST_DECEL: begin
                  if (runRise && runOk) state_r <= drs_pkg::ST_RUN;
                  else if (outFreqNow <= dcStartFreq) begin
                     waitCnt_r <= {8'h00, dcTime};
                     state_r <= drs_pkg::ST_BRAKE;
                  end
               end
               drs_pkg::ST_BRAKE: begin
                  if (waitCnt_r == 16'h0000) state_r <= drs_pkg::ST_IDLE;
                  else if (tick) waitCnt_r <= waitCnt_r - 16'h0001;
               end
               drs_pkg::ST_WAIT: begin
                  if (waitCnt_r == 16'h0000) begin
                     tries_r <= tries_r + 4'h1;
                     state_r <= drs_pkg::ST_RUN;
                  end else if (tick) waitCnt_r <= waitCnt_r - 16'h0001;
               end
               drs_pkg::ST_FAULT: begin
                  if (resetOk) begin
                     tries_r <= 4'h0;
                     state_r <= drs_pkg::ST_IDLE;
                  end
               end
               default: state_r <= drs_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Command output
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cmd <= '0;
      end else begin
         cmd.accelSet2 <= accelSet2;
         cmd.run <= state_r == drs_pkg::ST_RUN && !uv;
         cmd.coast <= !(state_r == drs_pkg::ST_RUN || state_r == drs_pkg::ST_DECEL);
         cmd.dcBrake <= state_r == drs_pkg::ST_BRAKE;
         cmd.dcLevel <= (dcLevel > drs_pkg::MAX_DCB_LEVEL) ? drs_pkg::MAX_DCB_LEVEL : dcLevel;
         // Zero whenever not running, so a stop never leaves a stale target
         if (state_r != drs_pkg::ST_RUN) begin
            cmd.freq <= 16'h0000;
         end else if (heldFreq_r != 16'h0000 && !seqMode_on) begin
            cmd.freq <= heldFreq_r;
         end else if (seqMode_on) begin
            cmd.freq <= cur.freq;
            cmd.dir <= cur.dir;
            if (cur.dir == drs_pkg::DIR_STOP) cmd.freq <= 16'h0000;
         end else begin
            cmd.freq <= keypadFreq;
            cmd.dir <= drs_pkg::DIR_FWD;
         end
      end
   end
   assign stepIdx = step_r;
   assign faulted = state_r == drs_pkg::ST_FAULT;
endmodule // drs_sequencer
`default_nettype wire

// *** drs_sequencer_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module drs_sequencer_properties (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic runSwitchPin,
   input wire logic underVoltagePin,
   input wire logic accelSet2,
   input wire logic stopMethod,
   input wire logic [4:0] dcLevel,
   input wire logic [15:0] dcStartFreq,
   input wire logic [15:0] outFreqNow,
   input wire drs_pkg::drs_cmd_t cmd,
   input wire logic faulted,
   input wire logic startBlockedIndication
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ---
   // Output drive
   // ---
   a_reset_clears: assert property (disable iff (1'b0) rst |=> cmd == '0 && !faulted && !startBlockedIndication)
      else $error("outputs not clear after reset");
   a_undervolt_off: assert property (underVoltagePin [*5] |-> !cmd.run)
      else $error("drive kept on under low supply");
   a_dir_legal: assert property (cmd.run |-> cmd.dir != 2'h3)
      else $error("undefined direction code");
   a_ramp_global: assert property (cmd.run |-> cmd.accelSet2 == accelSet2)
      else $error("ramp set differs from global select");
   a_block_norun: assert property (startBlockedIndication |-> !cmd.run)
      else $error("drive runs while start blocked");
   a_fault_norun: assert property ($rose(faulted) |=> !cmd.run)
      else $error("drive runs after fault");
   // ---
   // Stopping
   // ---
   a_brake_level: assert property (cmd.dcBrake |-> cmd.dcLevel == dcLevel)
      else $error("brake level differs from setting");
   // Speed only falls while stopping, so the present value is the safe one
   a_brake_start: assert property ($rose(cmd.dcBrake) |-> outFreqNow <= dcStartFreq)
      else $error("brake began above start frequency");
   a_coast_stop: assert property ((!runSwitchPin) [*5] ##0 (stopMethod && !faulted) |-> !cmd.run)
      else $error("drive not removed for coast");
   a_decel_stop: assert property ((!runSwitchPin) [*5] ##0 (!stopMethod && !faulted) |-> cmd.freq == 16'h0000)
      else $error("stop did not command zero");
endmodule // drs_sequencer_properties
bind drs_sequencer drs_sequencer_properties u_props (.ref_clk, .rst, .runSwitchPin, .underVoltagePin, .accelSet2,
   .stopMethod, .dcLevel, .dcStartFreq, .outFreqNow, .cmd, .faulted, .startBlockedIndication);
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int TB_TICK = 10;
   logic ref_clk = 1'b0, rst = 1'b1, runSwitchPin = 1'b1, faultResetPin = 1'b0, seqEnablePin = 1'b0;
   logic underVoltagePin = 1'b0, faultTrip = 1'b0, cpuPowerOk = 1'b1, extRunSource = 1'b1, accelSet2 = 1'b0;
   logic powerLossRestart = 1'b0, resetMode = 1'b0, directStartOff = 1'b1, stopMethod = 1'b0, faulted;
   logic startBlockedIndication;
   logic [2:0] seqMode = 3'h0, stepIdx, prevIdx = 3'h0;
   drs_pkg::drs_step_t [drs_pkg::NUM_STEPS-1:0] steps = '0;
   logic [15:0] keypadFreq = 16'h0800, dcStartFreq = 16'h0100, outFreqNow;
   logic [13:0] restartDelay = 14'h0000;
   logic [3:0] restartAttempts = 4'h0;
   logic [4:0] dcLevel = 5'h0A;
   logic [7:0] dcTime = 8'h03;
   logic [31:0] r;
   drs_pkg::drs_cmd_t cmd;
   int num_errors = 0, total_checks = 0, seed = 60, wraps = 0, p, m, w;
   always #5 ref_clk = ~ref_clk;
   drs_sequencer #(.TICK(TB_TICK)) u_dut (.ref_clk, .rst, .runSwitchPin, .faultResetPin, .seqEnablePin,
      .underVoltagePin, .faultTrip, .cpuPowerOk, .extRunSource, .seqMode, .steps, .keypadFreq, .outFreqNow,
      .accelSet2, .powerLossRestart, .restartDelay, .restartAttempts, .resetMode, .directStartOff, .dcStartFreq,
      .dcLevel, .dcTime, .stopMethod, .cmd, .stepIdx, .faulted, .startBlockedIndication);
   drs_motor_model u_motor (.ref_clk, .rst, .cmd, .outFreqNow);
   always @(posedge ref_clk) begin
      if (stepIdx == 3'h0 && prevIdx == 3'h3) wraps <= wraps + 1;
      prevIdx <= stepIdx;
   end
   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask
   task wt(input int k, input logic [2:0] v);
      logic [2:0] s;
      for (int i = 0; i < 2000; i++) begin
         s = k == 0 ? {2'b00, cmd.run} : k == 1 ? stepIdx : k == 2 ? {2'b00, faulted} : {2'b00, startBlockedIndication};
         if (s === v) break;
         cyc(1);
      end
      chk("waited output", {13'h0000, v}, {13'h0000, s});
   endtask
   task pulse(input int k);
      if (k == 1) faultResetPin = 1'b1;
      else faultTrip = 1'b1;
      cyc(4);
      faultResetPin = 1'b0;
      faultTrip = 1'b0;
      cyc(10);
   endtask
   task cycle_switch;
      runSwitchPin = 1'b0;
      cyc(10);
      wt(0, 3'h0);
      runSwitchPin = 1'b1;
      wt(0, 3'h1);
   endtask
   function automatic logic [15:0] exp_freq(input int i);
      return i == 0 ? keypadFreq : steps[i].freq;
   endfunction
   function automatic logic [2:0] exp_resume(input int mode, input logic [2:0] at);
      return mode <= drs_pkg::SEQ_RESUME_MAX ? at : 3'h0;
   endfunction
   function automatic int exp_wait(input logic [13:0] d);
      return int'(d == 14'h0000 ? drs_pkg::FIXED_WAIT_TENTHS : d) * TB_TICK;
   endfunction
   task test_done;
      $display("checks %0d, mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge ref_clk);
      num_errors++;
      $display("unexpected watchdog: expected finish, seen timeout");
      test_done;
   end
   initial begin
      cyc(16);
      rst = 1'b0;
      wt(3, 3'h1);
      chk("blocked run", 16'h0000, {15'h0000, cmd.run});
      cycle_switch;
      rst = 1'b1;
      directStartOff = 1'b0;
      cyc(16);
      rst = 1'b0;
      wt(0, 3'h1);
      $display("test power-up start done");
      for (p = 0; p < 2; p++) begin
         powerLossRestart = p[0];
         cyc(50);
         underVoltagePin = 1'b1;
         cyc(6);
         chk("undervoltage run", 16'h0000, {15'h0000, cmd.run});
         underVoltagePin = 1'b0;
         cyc(300);
         chk("run after supply", {15'h0000, p[0]}, {15'h0000, cmd.run});
         if (p == 0) cycle_switch;
      end
      chk("resumed freq", keypadFreq, cmd.freq);
      $display("test power loss done");
      pulse(0);
      wt(2, 3'h1);
      cyc(100);
      chk("run without attempts", 16'h0000, {15'h0000, cmd.run});
      pulse(1);
      chk("reset with run on", 16'h0001, {15'h0000, faulted});
      runSwitchPin = 1'b0;
      cyc(10);
      pulse(1);
      chk("reset with run off", 16'h0000, {15'h0000, faulted});
      cycle_switch;
      resetMode = 1'b1;
      pulse(0);
      pulse(1);
      chk("reset in mode one", 16'h0000, {15'h0000, faulted});
      cycle_switch;
      restartAttempts = 4'h3;
      for (p = 0; p < 2; p++) begin
         restartDelay = p ? 14'h0008 : 14'h0000;
         w = exp_wait(restartDelay);
         cyc(50);
         pulse(0);
         cyc(w - 30);
         chk("early restart", 16'h0000, {15'h0000, cmd.run});
         cyc(45);
         chk("auto restart", 16'h0001, {15'h0000, cmd.run});
         chk("restart freq", keypadFreq, cmd.freq);
      end
      runSwitchPin = 1'b0;
      cyc(6);
      chk("coast in decel", 16'h0000, {15'h0000, cmd.coast});
      pulse(0);
      cyc(150);
      chk("restart while stopping", 16'h0000, {15'h0000, cmd.run});
      chk("fault held while stopping", 16'h0001, {15'h0000, faulted});
      pulse(1);
      $display("test fault restart done");
      for (m = 1; m < 7; m++) begin
         // Fresh reset so a resume mode cannot inherit the last mode's step
         runSwitchPin = 1'b0;
         rst = 1'b1;
         cyc(2);
         rst = 1'b0;
         r = $random(seed);
         seqMode = m[2:0];
         stopMethod = 1'b1;
         accelSet2 = r[20];
         keypadFreq = {4'h0, r[31:20]} + 16'h0100;
         steps = '0;
         for (p = 0; p < 4; p++) begin
            r = $random(seed);
            steps[p] = '{16'h0100 + {4'h0, r[11:0]}, 16'h0003 + {13'h0000, r[14:12]},
               r[16] ? drs_pkg::DIR_REV : drs_pkg::DIR_FWD};
         end
         seqEnablePin = 1'b1;
         runSwitchPin = 1'b1;
         wt(1, 3'h2);
         cyc(2);
         chk("step freq", exp_freq(2), cmd.freq);
         chk("step dir", {14'h0000, steps[2].dir}, {14'h0000, cmd.dir});
         chk("ramp set", {15'h0000, accelSet2}, {15'h0000, cmd.accelSet2});
         runSwitchPin = 1'b0;
         cyc(10);
         chk("coast on stop", 16'h0001, {15'h0000, cmd.coast});
         runSwitchPin = 1'b1;
         wt(0, 3'h1);
         cyc(2);
         chk("resume step", {13'h0000, exp_resume(m, 3'h2)}, {13'h0000, stepIdx});
         chk("resume freq", exp_freq(exp_resume(m, 3'h2)), cmd.freq);
         w = wraps;
         cyc(600);
         if (m == 2 || m == 5) chk("cycle repeats", 16'h0001, {15'h0000, wraps > w});
         else chk("run after cycle", {15'h0000, m % 3 == 0}, {15'h0000, cmd.run});
         if (m % 3 == 0) chk("held freq", steps[3].freq, cmd.freq);
         $display("test sequencer mode %0d done", m);
      end
      test_done;
   end
endmodule // tb_top
`default_nettype wire
